// ==== verilog/msq_sequencer.sv ====
// Microprogram sequencer with maintenance panel paths and AXI4-Lite slave
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "msq_consts.svh"

module msq_sequencer (
  input  wire logic                    mclk,
  input  wire logic                    srst,
  input  wire logic [7:0]              panelSwitch,
  input  wire logic                    panelControlSwitch,
  input  wire logic                    startStopSetSwitch,
  output logic [`MSQ_PC_W-1:0]         csAddr,
  input  wire logic [31:0]             csData,
  output logic [`MSQ_RA_W-1:0]         registerAddressLine,
  input  wire logic [7:0]              regRdData,
  output logic [7:0]                   outDataBus,
  output logic                         stealCycle,
  output logic                         fetchTiming,
  output logic                         branchCycle,
  output logic                         processorHalt,
  output logic                         inhibitInstructionWrite,
  input  wire logic                    condLoad,
  input  wire logic [7:0]              condData,
  input  wire logic                    carryIn,
  input  wire logic [`MSQ_A_W-1:0]     awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  input  wire logic [`MSQ_A_W-1:0]     araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready
);

  logic [7:0]               swMeta;
  logic [7:0]               swSync;
  logic [2:0]               ctlSr;
  logic [2:0]               setSr;
  logic [7:0]               switchVal;
  logic                     ctlPulse;
  logic                     setPulse;
  logic                     writeDataMode_reg;
  logic                     addressSetMode_reg;
  logic                     highOrderInputFlag_reg;
  logic                     cmpBranchEn_reg;
  logic                     panelFetch_reg;
  logic [7:0]               panelWriteData_reg;
  logic [3:0]               panelAddressLatch_reg;
  logic                     anyMode;
  logic                     haltReq_reg;
  logic                     storeScanBit_reg;
  logic [`MSQ_PC_W-1:0]     stopAddress_reg;
  logic [3:0]               branchHigh_reg;
  logic                     scanValid_reg;
  logic                     parityErr;
  logic                     clrInhibit;
  logic                     clrCmp;
  logic [`MSQ_PC_W-1:0]     pc_reg;
  logic [31:0]              instructionRegister_reg;
  logic [7:0]               operand_reg;
  logic [7:0]               conditionRegister_reg;
  logic                     carryFlag_reg;
  logic [`MSQ_PC_W-1:0]     stack_reg [`MSQ_STACK_D];
  msq_pkg::msq_state_t      state_reg;
  msq_pkg::msq_op_t         op;
  logic                     isInd;
  logic                     isCall;
  logic                     isRtn;
  logic [7:0]               masked;
  logic                     condOk;
  logic                     taken;
  logic [`MSQ_PC_W-1:0]     seqPc;
  logic [`MSQ_PC_W-1:0]     target;
  logic [`MSQ_PC_W-1:0]     pc_next;
  logic                     push;
  logic                     pop;
  logic                     awHave_reg;
  logic                     wHave_reg;
  logic [`MSQ_A_W-1:0]      awAddr_reg;
  logic [31:0]              wData_reg;
  logic [3:0]               wStrb_reg;
  logic                     doWrite;
  logic                     ctrlWr;
  logic [31:0]              readMux;
  logic                     readHit;

  // Pins from the panel cross into mclk through two flops each
  always_ff @(posedge mclk) begin
    if (srst) begin
      swMeta <= 8'h00;
      swSync <= 8'h00;
      ctlSr  <= 3'h0;
      setSr  <= 3'h0;
    end else begin
      swMeta <= panelSwitch;
      swSync <= swMeta;
      ctlSr  <= {ctlSr[1:0], panelControlSwitch};
      setSr  <= {setSr[1:0], startStopSetSwitch};
    end
  end

  // Switch 0 becomes the most significant bit
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_rev
      assign switchVal[7-gi] = swSync[gi];
    end
  endgenerate

  assign ctlPulse = ctlSr[1] & ~ctlSr[2];
  assign setPulse = setSr[1] & ~setSr[2];
  assign anyMode  = writeDataMode_reg | addressSetMode_reg;

  // Panel input modes
  always_ff @(posedge mclk) begin
    if (srst) begin
      writeDataMode_reg      <= 1'b0;
      addressSetMode_reg     <= 1'b0;
      highOrderInputFlag_reg <= 1'b0;
      panelWriteData_reg     <= 8'h00;
      panelAddressLatch_reg  <= 4'h0;
    end else if (ctlPulse) begin
      if (switchVal[7:4] == `MSQ_PAT_WDATA) begin
        writeDataMode_reg <= 1'b1;
      end else if (switchVal[7:5] == `MSQ_PAT_ASET) begin
        addressSetMode_reg     <= 1'b1;
        highOrderInputFlag_reg <= 1'b1;
      end
    end else if (setPulse) begin
      if (writeDataMode_reg) begin
        panelWriteData_reg <= switchVal;
        writeDataMode_reg  <= 1'b0;
      end else if (addressSetMode_reg && highOrderInputFlag_reg) begin
        panelAddressLatch_reg  <= switchVal[7:4];
        highOrderInputFlag_reg <= 1'b0;
      end else if (addressSetMode_reg) begin
        addressSetMode_reg <= 1'b0;
      end
    end
  end

  // Compare-branch arming; software may disarm it
  always_ff @(posedge mclk) begin
    if (srst) begin
      cmpBranchEn_reg <= 1'b0;
    end else if (ctlPulse && switchVal[7:4] != `MSQ_PAT_WDATA
                 && switchVal[7:5] == `MSQ_PAT_CMPB) begin
      cmpBranchEn_reg <= 1'b1;
    end else if (clrCmp) begin
      cmpBranchEn_reg <= 1'b0;
    end
  end

  // Register write and display while halted
  always_ff @(posedge mclk) begin
    if (srst) begin
      stealCycle <= 1'b0;
      outDataBus <= 8'h00;
    end else begin
      stealCycle <= processorHalt & setPulse & ~anyMode;
      outDataBus <= processorHalt ? panelWriteData_reg : 8'h00;
    end
  end

  // Parity is odd over the whole word, parity bit included
  assign parityErr = scanValid_reg & ~(^csData);

  // Halt and inhibit; a parity error beats a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      inhibitInstructionWrite <= 1'b0;
      processorHalt           <= 1'b0;
    end else begin
      if (parityErr) begin
        inhibitInstructionWrite <= 1'b1;
      end else if (clrInhibit) begin
        inhibitInstructionWrite <= 1'b0;
      end
      processorHalt <= haltReq_reg | inhibitInstructionWrite | parityErr;
    end
  end

  // Decode of the word in the instruction register
  assign op     = msq_pkg::msq_op_t'(instructionRegister_reg[`MSQ_F_OP]);
  assign isInd  = instructionRegister_reg[`MSQ_F_IND];
  assign isCall = instructionRegister_reg[`MSQ_F_CALL];
  assign isRtn  = instructionRegister_reg[`MSQ_F_RTN];
  assign masked = operand_reg & instructionRegister_reg[`MSQ_F_MASK];
  assign seqPc  = pc_reg + `MSQ_PC_ONE;

  always_comb begin
    condOk = 1'b0;
    target = instructionRegister_reg[`MSQ_F_DEST];
    unique case (op)
      msq_pkg::OP_BRANCH: begin
        condOk = 1'b1;
        if (isInd) begin
          target = {instructionRegister_reg[`MSQ_F_DEST_HI], operand_reg};
        end
      end
      msq_pkg::OP_COND: begin
        unique case (msq_pkg::msq_bcond_t'(
                     instructionRegister_reg[`MSQ_F_BCOND]))
          msq_pkg::BC_ALL_ZERO:    condOk = conditionRegister_reg == 8'h00;
          msq_pkg::BC_CARRY_SET:   condOk = carryFlag_reg;
          msq_pkg::BC_ANY_ONE:     condOk = |conditionRegister_reg;
          msq_pkg::BC_CARRY_CLEAR: condOk = ~carryFlag_reg;
        endcase
        if (isInd) begin
          target = {instructionRegister_reg[`MSQ_F_DEST_HI], operand_reg};
        end
      end
      msq_pkg::OP_TEST: begin
        unique case (msq_pkg::msq_tcond_t'(
                     instructionRegister_reg[`MSQ_F_TCOND]))
          msq_pkg::TC_ALL_ZERO: condOk = masked == 8'h00;
          msq_pkg::TC_ALL_ONE:  condOk =
            masked == instructionRegister_reg[`MSQ_F_MASK];
          msq_pkg::TC_ANY_ONE:  condOk = |masked;
          msq_pkg::TC_ANY_ZERO: condOk =
            masked != instructionRegister_reg[`MSQ_F_MASK];
        endcase
        target = {pc_reg[`MSQ_PAGE_HI],
                  instructionRegister_reg[`MSQ_F_PAGE_OFF]};
      end
      msq_pkg::OP_ALU: begin
        condOk = 1'b0;
      end
    endcase
  end

  // Next address; a taken branch outranks a return, which applies whenever no branch is taken
  always_comb begin
    taken   = condOk & (op != msq_pkg::OP_ALU);
    push    = taken & isCall;
    pop     = isRtn & ~taken;
    pc_next = seqPc;
    if (taken) begin
      pc_next = target;
    end else if (isRtn) begin
      pc_next = stack_reg[0];
    end
  end

  // Return stack, four deep; overflow drops the oldest entry
  generate
    for (gi = 0; gi < `MSQ_STACK_D; gi++) begin : g_stack
      always_ff @(posedge mclk) begin
        if (srst) begin
          stack_reg[gi] <= `MSQ_PC_ZERO;
        end else if (state_reg == msq_pkg::ST_EXEC && push) begin
          stack_reg[gi] <= (gi == 0) ? seqPc : stack_reg[(gi == 0) ? 0 : gi-1];
        end else if (state_reg == msq_pkg::ST_EXEC && pop) begin
          stack_reg[gi] <= (gi == `MSQ_STACK_D-1) ? `MSQ_PC_ZERO
                           : stack_reg[(gi == `MSQ_STACK_D-1) ? gi : gi+1];
        end
      end
    end
  endgenerate

  // Condition register: test-bit calls own it during their execute cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      conditionRegister_reg <= 8'h00;
      carryFlag_reg         <= 1'b0;
    end else if (state_reg == msq_pkg::ST_EXEC && op == msq_pkg::OP_TEST
                 && isCall) begin
      conditionRegister_reg <= masked;
    end else if (condLoad) begin
      conditionRegister_reg <= condData;
      carryFlag_reg         <= carryIn;
    end
  end

  // Sequencer state machine, scan and panel address set
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg               <= msq_pkg::ST_FETCH;
      pc_reg                  <= `MSQ_PC_ZERO;
      csAddr                  <= `MSQ_PC_ZERO;
      instructionRegister_reg <= 32'h0000_0000;
      operand_reg             <= 8'h00;
      registerAddressLine     <= '0;
      fetchTiming             <= 1'b0;
      branchCycle             <= 1'b0;
      scanValid_reg           <= 1'b0;
      panelFetch_reg          <= 1'b0;
    end else begin
      branchCycle   <= 1'b0;
      scanValid_reg <= 1'b0;
      fetchTiming   <= 1'b0;
      if (setPulse && addressSetMode_reg && !highOrderInputFlag_reg) begin
        pc_reg         <= {panelAddressLatch_reg, switchVal};
        csAddr         <= {panelAddressLatch_reg, switchVal};
        panelFetch_reg <= 1'b1;
        state_reg      <= msq_pkg::ST_LOAD;
      end else if (storeScanBit_reg && !processorHalt) begin
        // Data returns one clock after its address, hence the valid flag
        fetchTiming             <= 1'b1;
        csAddr                  <= pc_reg;
        pc_reg                  <= seqPc;
        scanValid_reg           <= 1'b1;
        if (!parityErr) begin
          instructionRegister_reg <= csData;
        end
        state_reg               <= msq_pkg::ST_FETCH;
      end else begin
        unique case (state_reg)
          msq_pkg::ST_FETCH: begin
            if (processorHalt) begin
              registerAddressLine <= swSync[7:1];
            end else begin
              csAddr      <= pc_reg;
              fetchTiming <= 1'b1;
              state_reg   <= msq_pkg::ST_LOAD;
            end
          end
          msq_pkg::ST_LOAD: begin
            instructionRegister_reg <= csData;
            registerAddressLine     <= {1'b0, csData[`MSQ_F_SRC]};
            panelFetch_reg          <= 1'b0;
            state_reg <= panelFetch_reg ? msq_pkg::ST_FETCH
                                        : msq_pkg::ST_OPND;
          end
          msq_pkg::ST_OPND: begin
            operand_reg <= regRdData;
            if (op == msq_pkg::OP_TEST && isInd) begin
              registerAddressLine <= regRdData[`MSQ_RA_W-1:0];
              state_reg           <= msq_pkg::ST_OPND2;
            end else begin
              state_reg <= msq_pkg::ST_EXEC;
            end
          end
          msq_pkg::ST_OPND2: begin
            operand_reg <= regRdData;
            state_reg   <= msq_pkg::ST_EXEC;
          end
          msq_pkg::ST_EXEC: begin
            if (cmpBranchEn_reg && pc_next == stopAddress_reg) begin
              pc_reg      <= {branchHigh_reg, switchVal};
              branchCycle <= 1'b1;
            end else begin
              pc_reg <= pc_next;
            end
            state_reg <= msq_pkg::ST_FETCH;
          end
        endcase
      end
    end
  end

  // AXI4-Lite write side: address and data taken in either order
  assign doWrite    = awHave_reg & wHave_reg & ~bvalid;
  assign ctrlWr     = doWrite & (awAddr_reg == `MSQ_A_CTRL) & wStrb_reg[0];
  assign clrInhibit = ctrlWr & wData_reg[`MSQ_C_CLRINH];
  assign clrCmp     = ctrlWr & wData_reg[`MSQ_C_CLRCMP];

  always_ff @(posedge mclk) begin
    if (srst) begin
      awready    <= 1'b1;
      wready     <= 1'b1;
      awHave_reg <= 1'b0;
      wHave_reg  <= 1'b0;
      awAddr_reg <= '0;
      wData_reg  <= 32'h0000_0000;
      wStrb_reg  <= 4'h0;
      bvalid     <= 1'b0;
      bresp      <= `MSQ_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awAddr_reg <= awaddr;
        awHave_reg <= 1'b1;
        awready    <= 1'b0;
      end
      if (wvalid && wready) begin
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
        wHave_reg <= 1'b1;
        wready    <= 1'b0;
      end
      if (doWrite) begin
        awHave_reg <= 1'b0;
        wHave_reg  <= 1'b0;
        bvalid     <= 1'b1;
        bresp      <= (awAddr_reg == `MSQ_A_CTRL ||
                       awAddr_reg == `MSQ_A_STOP ||
                       awAddr_reg == `MSQ_A_BRHI) ? `MSQ_RESP_OKAY
                                                  : `MSQ_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // Writable registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      haltReq_reg      <= 1'b0;
      storeScanBit_reg <= 1'b0;
      stopAddress_reg  <= `MSQ_PC_ZERO;
      branchHigh_reg   <= 4'h0;
    end else if (doWrite) begin
      if (ctrlWr) begin
        haltReq_reg      <= wData_reg[`MSQ_C_HALT];
        storeScanBit_reg <= wData_reg[`MSQ_C_SCAN];
      end
      if (awAddr_reg == `MSQ_A_STOP) begin
        if (wStrb_reg[0]) stopAddress_reg[7:0] <= wData_reg[7:0];
        if (wStrb_reg[1]) stopAddress_reg[11:8] <= wData_reg[11:8];
      end
      if (awAddr_reg == `MSQ_A_BRHI && wStrb_reg[0]) begin
        branchHigh_reg <= wData_reg[3:0];
      end
    end
  end

  // AXI4-Lite read side; unmapped reads return zero with SLVERR
  always_comb begin
    readHit = 1'b1;
    readMux = 32'h0000_0000;
    unique case (araddr)
      `MSQ_A_CTRL:   readMux = {30'h0, storeScanBit_reg, haltReq_reg};
      `MSQ_A_STOP:   readMux = {20'h0, stopAddress_reg};
      `MSQ_A_BRHI:   readMux = {28'h0, branchHigh_reg};
      `MSQ_A_STATUS: readMux = {3'h0, state_reg, cmpBranchEn_reg,
                                highOrderInputFlag_reg, addressSetMode_reg,
                                writeDataMode_reg, inhibitInstructionWrite,
                                processorHalt, panelWriteData_reg, pc_reg};
      `MSQ_A_COND:   readMux = {23'h0, carryFlag_reg, conditionRegister_reg};
      `MSQ_A_INSTR:  readMux = instructionRegister_reg;
      default:       readHit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `MSQ_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= readMux;
      rresp   <= readHit ? `MSQ_RESP_OKAY : `MSQ_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule : msq_sequencer

// ==== include/msq_consts.svh ====
// Constants of the microsequencer: fields, register map and patterns
`ifndef MSQ_CONSTS_SVH
`define MSQ_CONSTS_SVH
`define MSQ_PC_W        12
`define MSQ_RA_W        7
`define MSQ_STACK_D     4
`define MSQ_PC_ZERO     12'h000
`define MSQ_PC_ONE      12'h001
// Instruction word fields
`define MSQ_F_OP        1:0
`define MSQ_F_IND       2
`define MSQ_F_CALL      3
`define MSQ_F_RTN       4
`define MSQ_F_SRC       10:5
`define MSQ_F_MASK      18:11
`define MSQ_F_DEST      30:19
`define MSQ_F_DEST_HI   30:27
`define MSQ_F_PAGE_OFF  27:19
`define MSQ_F_BCOND     12:11
`define MSQ_F_TCOND     30:29
`define MSQ_PAGE_HI     11:9
// Panel switch patterns, switch 0 in the high bit
`define MSQ_PAT_WDATA   4'hb
`define MSQ_PAT_ASET    3'h5
`define MSQ_PAT_CMPB    3'h6
// Register map, byte addresses
`define MSQ_A_CTRL      8'h00
`define MSQ_A_STOP      8'h04
`define MSQ_A_BRHI      8'h08
`define MSQ_A_STATUS    8'h0c
`define MSQ_A_COND      8'h10
`define MSQ_A_INSTR     8'h14
`define MSQ_A_W         8
// Control register bits
`define MSQ_C_HALT      0
`define MSQ_C_SCAN      1
`define MSQ_C_CLRINH    2
`define MSQ_C_CLRCMP    3
`define MSQ_RESP_OKAY   2'h0
`define MSQ_RESP_SLVERR 2'h2
`endif

// ==== include/msq_pkg.sv ====
// Types shared by the microsequencer
package msq_pkg;
  typedef enum logic [1:0] {
    OP_BRANCH, OP_COND, OP_TEST, OP_ALU
  } msq_op_t;
  typedef enum logic [1:0] {
    BC_ALL_ZERO, BC_CARRY_SET, BC_ANY_ONE, BC_CARRY_CLEAR
  } msq_bcond_t;
  typedef enum logic [1:0] {
    TC_ALL_ZERO, TC_ALL_ONE, TC_ANY_ONE, TC_ANY_ZERO
  } msq_tcond_t;
  typedef enum logic [2:0] {
    ST_FETCH, ST_LOAD, ST_OPND, ST_OPND2, ST_EXEC
  } msq_state_t;
endpackage : msq_pkg

// ==== bench/msq_checker.sv ====
// Port assertions for the microsequencer
`timescale 1ns/100ps
`include "msq_consts.svh"
module msq_checker (
  input wire logic                  mclk,
  input wire logic                  srst,
  input wire logic                  processorHalt,
  input wire logic                  stealCycle,
  input wire logic                  branchCycle,
  input wire logic                  inhibitInstructionWrite,
  input wire logic                  fetchTiming,
  input wire logic [7:0]            outDataBus,
  input wire logic [`MSQ_PC_W-1:0]  csAddr,
  input wire logic                  awready,
  input wire logic                  bvalid,
  input wire logic                  arvalid,
  input wire logic                  arready,
  input wire logic                  rvalid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // Two quiet cycles, since the bus follows the halt one register late
  a_idle_bus: assert property (!processorHalt && !$past(processorHalt)
    |-> outDataBus == 8'h00) else $error("output bus driven while running");
  a_steal_halted: assert property (stealCycle |-> $past(processorHalt))
    else $error("steal cycle while running");
  a_steal_pulse: assert property (stealCycle |=> !stealCycle)
    else $error("steal cycle longer than one cycle");
  a_branch_pulse: assert property (branchCycle |=> !branchCycle)
    else $error("branch cycle longer than one cycle");
  // Three running fetch cycles in a row occur only while scanning
  a_scan_count: assert property ((fetchTiming && !processorHalt) [*3]
    |-> csAddr == $past(csAddr) + 12'h001) else $error("scan skipped");
  a_inhibit_halt: assert property (inhibitInstructionWrite |=> processorHalt)
    else $error("inhibit without halt");
  a_inhibit_scan: assert property ($rose(inhibitInstructionWrite)
    |-> $past(fetchTiming)) else $error("inhibit outside scan");
  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read not answered in one cycle");
  a_write_busy: assert property (bvalid |-> !awready)
    else $error("write address taken during response");
  cover property (stealCycle);
  cover property ($rose(inhibitInstructionWrite));
  cover property (arvalid && arready ##1 rvalid);
  cover property (branchCycle);
endmodule : msq_checker
bind msq_sequencer msq_checker u_msq_checker (.mclk, .srst, .processorHalt,
  .stealCycle, .branchCycle, .inhibitInstructionWrite, .fetchTiming,
  .outDataBus, .csAddr, .awready, .bvalid, .arvalid, .arready, .rvalid);

// ==== bench/msq_store_model.sv ====
// Control store and register file on the far side of the sequencer
`timescale 1ns/100ps
`include "msq_consts.svh"
module msq_store_model (
  input  wire logic [`MSQ_PC_W-1:0] csAddr,
  output logic [31:0]               csData,
  input  wire logic [`MSQ_RA_W-1:0] registerAddressLine,
  output logic [7:0]                regRdData
);
  logic [31:0] mem [0:4095];
  logic [7:0]  rf  [0:127];
  // Plain combinational read: no access time beyond the one allowed cycle
  assign csData    = mem[csAddr];
  assign regRdData = rf[registerAddressLine];
endmodule : msq_store_model

// ==== bench/tb_top.sv ====
// Self-checking bench for the microsequencer
`timescale 1ns/100ps
`include "msq_consts.svh"
module tb_top;
  logic        mclk = 0, srst = 1, condLoad = 0, carryIn = 0;
  logic        panelControlSwitch = 0, startStopSetSwitch = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        stealCycle, fetchTiming, branchCycle, processorHalt;
  logic        inhibitInstructionWrite, awready, wready, bvalid;
  logic        arready, rvalid;
  logic [7:0]  panelSwitch = 0, condData = 0, awaddr = 0, araddr = 0;
  logic [7:0]  regRdData, outDataBus, r, wd;
  logic [11:0] csAddr;
  logic [6:0]  registerAddressLine;
  logic [31:0] csData, wdata = 0, rdata, rv;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp;
  logic [11:0] expq [$];
  int          bad_count = 0, comparisons = 0, steals = 0, i;
  msq_sequencer u_msq_sequencer (.mclk, .srst, .panelSwitch,
    .panelControlSwitch, .startStopSetSwitch, .csAddr, .csData,
    .registerAddressLine, .regRdData, .outDataBus, .stealCycle, .fetchTiming,
    .branchCycle, .processorHalt, .inhibitInstructionWrite, .condLoad,
    .condData, .carryIn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready);
  msq_store_model u_msq_store_model (.csAddr, .csData, .registerAddressLine,
    .regRdData);
  task give_verdict;
    if (bad_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge mclk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk("bresp", e, bresp);
  endtask : wr
  task rd(input logic [7:0] a, input logic [1:0] e);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge mclk);
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    rv = rdata;
    chk("rresp", e, rresp);
  endtask : rd
  // Switch bit i is switch i, so the value's top bit lands on switch 0
  task pnl(input logic c, input logic [7:0] v);
    for (int k = 0; k < 8; k++) panelSwitch[k] <= v[7-k];
    repeat (4) @(posedge mclk);
    if (c) panelControlSwitch <= 1'h1;
    else startStopSetSwitch <= 1'h1;
    repeat (4) @(posedge mclk);
    panelControlSwitch <= 1'h0;
    startStopSetSwitch <= 1'h0;
    repeat (6) @(posedge mclk);
  endtask : pnl
  function logic [31:0] enc(input logic [1:0] op, input logic [2:0] f,
    input logic [5:0] s, input logic [7:0] m, input logic [11:0] d);
    enc = {1'h0, d, m, s, f, op};
    enc[31] = ~^enc[30:0];
  endfunction : enc
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    if (fetchTiming === 1'h1 && expq.size() > 0)
      chk("fetch address", expq.pop_front(), csAddr);
    if (stealCycle === 1'h1) begin
      steals++;
      chk("register address", panelSwitch[7:1], registerAddressLine);
      chk("write data", wd, outDataBus);
    end
  end
  // Tests need about 300 cycles
  initial begin
    #500000;
    bad_count++;
    give_verdict;
  end
  initial begin
    i = $urandom(16);
    for (i = 0; i < 4096; i++) u_msq_store_model.mem[i] = enc(3, 0, 0, 0, 0);
    for (i = 0; i < 128; i++) u_msq_store_model.rf[i] = $urandom;
    r = $urandom;
    r[7:6] = 2'h0;
    u_msq_store_model.rf[3] = r;
    u_msq_store_model.rf[5] = u_msq_store_model.rf[5] | 8'h01;
    u_msq_store_model.rf[6] = 8'h00;
    u_msq_store_model.mem[12'h000] = enc(0, 0, 0, 8'h00, 12'h040);
    u_msq_store_model.mem[12'h040] = enc(0, 2, 0, 8'h00, 12'h080);
    u_msq_store_model.mem[12'h080] = enc(3, 4, 0, 8'h00, 12'h000);
    u_msq_store_model.mem[12'h041] = enc(1, 3, 6, 8'h00, 12'h200);
    u_msq_store_model.mem[12'h200] = enc(1, 0, 0, 8'h01, 12'h600);
    u_msq_store_model.mem[12'h201] = enc(2, 2, 5, 8'h01, 12'h820);
    u_msq_store_model.mem[12'h220] = enc(0, 1, 3, 8'h00, 12'h300);
    u_msq_store_model.mem[{4'h3, r}] = enc(0, 0, 0, 8'h00, {4'h3, r});
    expq = '{12'h000, 12'h040, 12'h080, 12'h041, 12'h200, 12'h201, 12'h220,
      {4'h3, r}, {4'h3, r}};
    repeat (2) @(posedge mclk);
    srst <= 1'h0;
    rd(`MSQ_A_CTRL, 2'h0);
    chk("control", 32'h0, rv);
    for (i = 0; i < 200 && expq.size() > 0; i++) @(posedge mclk);
    chk("fetches left", 0, expq.size());
    // The test-bit call leaves its AND result behind
    rd(`MSQ_A_COND, 2'h0);
    chk("condition", 32'h1, rv);
    wr(`MSQ_A_CTRL, 32'h1, 2'h0);
    repeat (10) @(posedge mclk);
    wd = $urandom;
    pnl(1, 8'hb0);
    pnl(0, wd);
    chk("output bus", wd, outDataBus);
    pnl(0, $urandom);
    chk("steal count", 1, steals);
    pnl(1, 8'ha0);
    pnl(0, 8'h30);
    rd(`MSQ_A_STATUS, 2'h0);
    chk("high order flag", 0, rv[24]);
    pnl(0, 8'h77);
    rd(`MSQ_A_STATUS, 2'h0);
    chk("set address", 12'h377, rv[11:0]);
    rd(`MSQ_A_INSTR, 2'h0);
    chk("set word", u_msq_store_model.mem[12'h377], rv);
    u_msq_store_model.mem[12'h380] = u_msq_store_model.mem[12'h380] ^ 32'h1;
    wr(`MSQ_A_CTRL, 32'h2, 2'h0);
    for (i = 0; i < 100 && inhibitInstructionWrite !== 1'h1; i++)
      @(posedge mclk);
    repeat (3) @(posedge mclk);
    rd(`MSQ_A_STATUS, 2'h0);
    chk("inhibit and halt", 2'h3, rv[21:20]);
    rd(`MSQ_A_INSTR, 2'h0);
    chk("scanned word", u_msq_store_model.mem[12'h37f], rv);
    rd(8'h40, 2'h2);
    chk("unmapped", 32'h0, rv);
    wr(`MSQ_A_STATUS, 32'h0, 2'h2);
    // Resume past the scan stop and let the armed compare redirect
    wr(`MSQ_A_STOP, 32'h390, 2'h0);
    wr(`MSQ_A_BRHI, 32'h5, 2'h0);
    pnl(1, 8'hc0);
    wr(`MSQ_A_CTRL, 32'h4, 2'h0);
    for (i = 0; i < 200 && branchCycle !== 1'h1; i++) @(posedge mclk);
    chk("branch cycle", 1, branchCycle);
    expq.push_back(12'h5c0);
    repeat (3) @(posedge mclk);
    chk("branch fetches", 0, expq.size());
    give_verdict;
  end
endmodule : tb_top
